// *** hw/tws_pkg.sv ***
/*
  Shared constants and types for the two-wire serial engine: bit timing,
  data widths, command codes and the state encodings of both ends.
  Assumes a single 125 MHz system clock on each end and an open-drain bus
  resolved by the tws_bus_if interface.
*/
// Behaviour
// - lines are open-drain: pull low, release high
// - start is sda falling while scl high
// - start followed by address and direction bit
// - direction one reads, zero writes
// - bytes shift most significant bit first
// - addressed slave acknowledges, then takes complementary role
// - acknowledge is sda held low
// - data changes only while scl low
// - nine-bit segment: eight data plus acknowledge
// - transmitter releases sda for acknowledge bit
// - master drives scl, receivers sample on rise
// - master write: slave acknowledges every byte
// - master read: acknowledge each, last gets none
// - stop is sda rising while scl high
// - repeated start may replace stop
// - single writes, reads and combined messages supported
// - slave may stretch scl low when busy
// - master waits until released scl reads high
// - track bus busy; start only when idle
// - sda mismatch while sending loses arbitration
// - loser releases scl, waits for stop
// - winner continues; slave transmitters arbitrate too
package tws_pkg;

  localparam int CLK_NS       = 8;    // system clock period
  localparam int QTR_NS       = 625;  // quarter of the scl period, 400 kHz bus
  localparam int QTR_CYC      = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W        = 7;
  localparam int DATA_W       = 8;
  localparam int FIFO_DEPTH   = 16;
  localparam int SEG_BITS     = 9;
  localparam logic [TMR_W-1:0] QTR_RELOAD = TMR_W'(QTR_CYC - 1);
  localparam logic [3:0]  LAST_BIT    = 4'(SEG_BITS - 1);
  localparam logic [3:0]  BYTE_BITS   = 4'(DATA_W);
  localparam logic [6:0]  SLAVE_ADDR  = 7'h2A;  // far-end address, plain default
  localparam logic [1:0]  LINES_IDLE  = 2'h3;   // {scl, sda} both released

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } tws_cmd_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BIT   = 5'h04,
    M_STOP  = 5'h08,
    M_LOST  = 5'h10
  } tws_mstate_t;

  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_RECV   = 6'h02,
    S_ACK    = 6'h04,
    S_LOAD   = 6'h08,
    S_SEND   = 6'h10,
    S_GETACK = 6'h20
  } tws_sstate_t;

endpackage

// *** hw/tws_bus_if.sv ***
/*
  The two-wire bus between the engine (master end) and the far end (slave).
  Each end drives output value and active-low enable; the wired level is
  resolved here, which stands in for the pull-up resistors.
*/
interface tws_bus_if;

  logic mSclOut;
  logic mSclOeN;
  logic mSdaOut;
  logic mSdaOeN;
  logic sSclOut;
  logic sSclOeN;
  logic sSdaOut;
  logic sSdaOeN;
  logic scl;
  logic sda;

  // wired-and: a line is high unless some end enables a low drive
  assign scl = (mSclOeN | mSclOut) & (sSclOeN | sSclOut);
  assign sda = (mSdaOeN | mSdaOut) & (sSdaOeN | sSdaOut);

  modport master
  (
    input  scl,
    input  sda,
    output mSclOut,
    output mSclOeN,
    output mSdaOut,
    output mSdaOeN
  );

  modport slave
  (
    input  scl,
    input  sda,
    output sSclOut,
    output sSclOeN,
    output sSdaOut,
    output sSdaOeN
  );

endinterface

// *** hw/tws_engine.sv ***
/*
  Master end of the two-wire engine plus its receive FIFO. Commands arrive
  one at a time on a valid/ready port; read bytes leave through the FIFO.
  Assumes the bus interface resolves open-drain levels and that the user
  keeps cmdValid and its fields steady until cmdReady.
*/
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             resetN,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [CW-1:0]    wrIdx;
  logic             valid_q;
  wire              push = inValid && inReady;
  wire              pop  = valid_q && outReady;

  // shift fifo: the head always sits in entry 0, so the output is a flop
  assign inReady  = (count_q != CW'(DEPTH));
  assign wrIdx    = pop ? count_q - CW'(1) : count_q;
  assign count_d  = count_q + CW'(push) - CW'(pop);
  assign outValid = valid_q;
  assign outData  = mem_q[0];

  always_ff @(posedge clk or negedge resetN)
    if (!resetN)
    begin
      count_q <= '0;
      valid_q <= 1'h0;
    end
    else
    begin
      count_q <= count_d;
      valid_q <= (count_d != '0);
    end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : gEntry
      always_ff @(posedge clk or negedge resetN)
        if (!resetN)
          mem_q[i] <= '0;
        else if (push && wrIdx == CW'(i))
          mem_q[i] <= inData;
        else if (pop && i < DEPTH - 1)
          mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
    end
  endgenerate

endmodule

module tws_master
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  tws_bus_if.master                  bus,
  input  wire logic                  cmdValid,
  output logic                       cmdReady,
  input  wire tws_pkg::tws_cmd_t     cmdCode,
  input  wire logic [7:0]            cmdData,
  input  wire logic                  cmdLast,
  output logic                       done,
  output logic                       nack,
  output logic                       arbLost,
  output logic                       busBusy,
  output logic                       rxValid,
  input  wire logic                  rxReady,
  output logic [7:0]                 rxData
);

  logic [1:0]                  sync1_q;
  logic [1:0]                  sync2_q;
  logic [1:0]                  sync3_q;
  logic [1:0]                  line_q;
  logic [1:0]                  line_d;
  tws_pkg::tws_mstate_t        state_q;
  logic [1:0]                  phase_q;
  logic [tws_pkg::TMR_W-1:0]   timer_q;
  logic [3:0]                  bitCnt_q;
  logic [8:0]                  shift_q;
  logic [8:0]                  recv_q;
  logic                        isWrite_q;
  logic                        own_q;
  logic                        busy_q;
  logic                        sclOeN_q;
  logic                        sdaOeN_q;
  logic                        cmdReady_q;
  logic                        done_q;
  logic                        nack_q;
  logic                        lost_q;
  logic                        push_q;
  logic                        fifoRoom;

  // three-stage synchroniser; a change counts once stages two and three agree
  assign line_d = (sync2_q & sync3_q) | (line_q & (sync2_q ^ sync3_q));

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sync1_q <= tws_pkg::LINES_IDLE;
      sync2_q <= tws_pkg::LINES_IDLE;
      sync3_q <= tws_pkg::LINES_IDLE;
      line_q  <= tws_pkg::LINES_IDLE;
    end
    else
    begin
      sync1_q <= {bus.scl, bus.sda};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      line_q  <= line_d;
    end

  // bus conditions, seen on the filtered lines
  wire sclHigh  = line_q[1];
  wire sdaHigh  = line_q[0];
  wire startDet = line_q[1] && line_d[1] && line_q[0] && !line_d[0];
  wire stopDet  = line_q[1] && line_d[1] && !line_q[0] && line_d[0];

  // busy from any start until the next stop, whoever made them
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      busy_q <= 1'h0;
    else if (startDet || stopDet)
      busy_q <= startDet;

  // quarter-period pacing; phase 2 holds while scl is still held low
  wire accept    = cmdValid && cmdReady_q;
  wire tick      = (timer_q == '0);
  wire waitHigh  = (phase_q == 2'h2) && !sclHigh;
  wire waitIdle  = (state_q == tws_pkg::M_START) && (phase_q == 2'h0) && !own_q && busy_q;
  wire running   = (state_q != tws_pkg::M_IDLE) && (state_q != tws_pkg::M_LOST);
  wire step      = running && tick && !waitHigh && !waitIdle;
  wire arbCheck  = isWrite_q && (bitCnt_q != tws_pkg::LAST_BIT);
  wire lastBit   = (bitCnt_q == tws_pkg::LAST_BIT);

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      timer_q <= '0;
    else if (accept || step)
      timer_q <= tws_pkg::QTR_RELOAD;
    else if (!tick)
      timer_q <= timer_q - tws_pkg::TMR_W'(1);

  // command window: every command waits for fifo room, so the fifo stalls the engine
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      cmdReady_q <= 1'h0;
    else
      cmdReady_q <= (state_q == tws_pkg::M_IDLE) && !accept && !push_q && fifoRoom;

  // protocol sequencer: each phase ends on a quarter tick
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_q   <= tws_pkg::M_IDLE;
      phase_q   <= 2'h0;
      bitCnt_q  <= 4'h0;
      shift_q   <= 9'h1FF;
      recv_q    <= 9'h000;
      isWrite_q <= 1'h0;
      own_q     <= 1'h0;
      sclOeN_q  <= 1'h1;
      sdaOeN_q  <= 1'h1;
      done_q    <= 1'h0;
      nack_q    <= 1'h0;
      lost_q    <= 1'h0;
      push_q    <= 1'h0;
    end
    else
    begin
      done_q <= 1'h0;
      lost_q <= 1'h0;
      push_q <= 1'h0;
      if (step)
        phase_q <= phase_q + 2'h1;
      case (state_q)
        tws_pkg::M_IDLE:
          if (accept)
          begin
            phase_q   <= 2'h0;
            bitCnt_q  <= 4'h0;
            isWrite_q <= (cmdCode == tws_pkg::CMD_WRITE);
            // write: byte then a released ack slot; read: released byte then our ack, or a released slot when cmdLast
            shift_q   <= (cmdCode == tws_pkg::CMD_WRITE) ? {cmdData, 1'h1} : {8'hFF, cmdLast};
            if (cmdCode == tws_pkg::CMD_START)
              state_q <= tws_pkg::M_START;
            else if (!own_q)
              done_q <= 1'h1; // nothing to do without the bus
            else if (cmdCode == tws_pkg::CMD_STOP)
              state_q <= tws_pkg::M_STOP;
            else
              state_q <= tws_pkg::M_BIT;
          end
        tws_pkg::M_START:
          if (step)
            case (phase_q)
              2'h0: sdaOeN_q <= 1'h1;
              2'h1: sclOeN_q <= 1'h1;
              2'h2:
                if (!own_q && !sdaHigh)
                begin
                  state_q <= tws_pkg::M_LOST; // someone else pulled sda first
                  lost_q  <= 1'h1;
                end
                else
                  sdaOeN_q <= 1'h0;
              default:
              begin
                sclOeN_q <= 1'h0;
                own_q    <= 1'h1;
                done_q   <= 1'h1;
                state_q  <= tws_pkg::M_IDLE;
              end
            endcase
        tws_pkg::M_BIT:
          if (step)
            case (phase_q)
              2'h0: sdaOeN_q <= shift_q[8];
              2'h1: sclOeN_q <= 1'h1;
              2'h2:
              begin
                recv_q <= {recv_q[7:0], sdaHigh};
                if (arbCheck && shift_q[8] && !sdaHigh)
                begin
                  sdaOeN_q <= 1'h1;
                  own_q    <= 1'h0;
                  lost_q   <= 1'h1;
                  state_q  <= tws_pkg::M_LOST;
                end
              end
              default:
              begin
                sclOeN_q <= 1'h0;
                shift_q  <= {shift_q[7:0], 1'h1};
                bitCnt_q <= bitCnt_q + 4'h1;
                if (lastBit)
                begin
                  done_q  <= 1'h1;
                  nack_q  <= recv_q[0];
                  push_q  <= !isWrite_q;
                  state_q <= tws_pkg::M_IDLE;
                end
              end
            endcase
        tws_pkg::M_STOP:
          if (step)
            case (phase_q)
              2'h0: sdaOeN_q <= 1'h0;
              2'h1: sclOeN_q <= 1'h1;
              2'h2: sdaOeN_q <= 1'h1;
              default:
              begin
                own_q   <= 1'h0;
                done_q  <= 1'h1;
                state_q <= tws_pkg::M_IDLE;
              end
            endcase
        default:
        begin
          // lost: both lines released until a stop frees the bus
          sclOeN_q <= 1'h1;
          sdaOeN_q <= 1'h1;
          own_q    <= 1'h0;
          if (stopDet)
            state_q <= tws_pkg::M_IDLE;
        end
      endcase
    end

  tws_fifo #(
    .WIDTH (tws_pkg::DATA_W),
    .DEPTH (tws_pkg::FIFO_DEPTH)
  ) uRxFifo (
    .clk      (ref_clk),
    .resetN   (reset_n),
    .inValid  (push_q),
    .inReady  (fifoRoom),
    .inData   (recv_q[8:1]),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  assign bus.mSclOut = 1'h0; // open-drain: only the enable moves
  assign bus.mSdaOut = 1'h0;
  assign bus.mSclOeN = sclOeN_q;
  assign bus.mSdaOeN = sdaOeN_q;
  assign cmdReady    = cmdReady_q;
  assign done        = done_q;
  assign nack        = nack_q;
  assign arbLost     = lost_q;
  assign busBusy     = busy_q;

endmodule

// *** hw/tws_far_end.sv ***
/*
  Far end of the two-wire bus: a slave at a fixed address that hands written
  bytes to its user and fetches bytes to send on reads. Assumes the master
  end paces scl slowly enough for a few cycles of synchroniser delay.
*/
module tws_far_end
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  tws_bus_if.slave        bus,
  output logic            wrValid,
  input  wire logic       wrReady,
  output logic [7:0]      wrData,
  input  wire logic       rdValid,
  output logic            rdReady,
  input  wire logic [7:0] rdData
);

  logic [1:0]            sync1_q;
  logic [1:0]            sync2_q;
  logic [1:0]            sync3_q;
  logic [1:0]            line_q;
  logic [1:0]            line_d;
  tws_pkg::tws_sstate_t  state_q;
  logic [3:0]            bitCnt_q;
  logic [7:0]            shift_q;
  logic                  isAddr_q;
  logic                  rw_q;
  logic                  ackN_q;
  logic                  sclOeN_q;
  logic                  sdaOeN_q;
  logic                  wrValid_q;
  logic [7:0]            wrData_q;
  logic                  rdReady_q;

  assign line_d = (sync2_q & sync3_q) | (line_q & (sync2_q ^ sync3_q));

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sync1_q <= tws_pkg::LINES_IDLE;
      sync2_q <= tws_pkg::LINES_IDLE;
      sync3_q <= tws_pkg::LINES_IDLE;
      line_q  <= tws_pkg::LINES_IDLE;
    end
    else
    begin
      sync1_q <= {bus.scl, bus.sda};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      line_q  <= line_d;
    end

  wire rise     = !line_q[1] && line_d[1];
  wire fall     = line_q[1] && !line_d[1];
  wire sdaNow   = line_d[0];
  wire startDet = line_q[1] && line_d[1] && line_q[0] && !line_d[0];
  wire stopDet  = line_q[1] && line_d[1] && !line_q[0] && line_d[0];
  wire byteDone = (bitCnt_q == tws_pkg::BYTE_BITS);
  wire addrHit  = (shift_q[7:1] == tws_pkg::SLAVE_ADDR);

  // slave sequencer; any start resets it to take an address
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_q   <= tws_pkg::S_IDLE;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      isAddr_q  <= 1'h0;
      rw_q      <= 1'h0;
      ackN_q    <= 1'h1;
      sclOeN_q  <= 1'h1;
      sdaOeN_q  <= 1'h1;
      wrValid_q <= 1'h0;
      wrData_q  <= 8'h00;
      rdReady_q <= 1'h0;
    end
    else
    begin
      rdReady_q <= 1'h0;
      if (stopDet)
      begin
        state_q  <= tws_pkg::S_IDLE;
        sclOeN_q <= 1'h1;
        sdaOeN_q <= 1'h1;
      end
      else if (startDet)
      begin
        state_q  <= tws_pkg::S_RECV;
        isAddr_q <= 1'h1;
        bitCnt_q <= 4'h0;
        sclOeN_q <= 1'h1;
        sdaOeN_q <= 1'h1;
      end
      else
        case (state_q)
          tws_pkg::S_RECV:
            if (rise)
            begin
              shift_q  <= {shift_q[6:0], sdaNow};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
            else if (fall && byteDone)
            begin
              if (isAddr_q && !addrHit)
                state_q <= tws_pkg::S_IDLE; // not ours: stay off the bus
              else
              begin
                sdaOeN_q <= 1'h0;
                state_q  <= tws_pkg::S_ACK;
                if (isAddr_q)
                  rw_q <= shift_q[0];
                else
                begin
                  wrValid_q <= 1'h1;
                  wrData_q  <= shift_q;
                  sclOeN_q  <= 1'h0;
                end
              end
            end
          tws_pkg::S_ACK:
            if (wrValid_q)
            begin
              // hold scl until the user takes the byte
              if (wrReady)
              begin
                wrValid_q <= 1'h0;
                sclOeN_q  <= 1'h1;
              end
            end
            else if (fall)
            begin
              sdaOeN_q <= 1'h1;
              bitCnt_q <= 4'h0;
              isAddr_q <= 1'h0;
              if (rw_q)
              begin
                sclOeN_q <= 1'h0;
                state_q  <= tws_pkg::S_LOAD;
              end
              else
                state_q <= tws_pkg::S_RECV;
            end
          tws_pkg::S_LOAD:
            if (rdValid && !rdReady_q)
            begin
              rdReady_q <= 1'h1;
              shift_q   <= rdData;
              sdaOeN_q  <= rdData[7];
              sclOeN_q  <= 1'h1;
              bitCnt_q  <= 4'h0;
              state_q   <= tws_pkg::S_SEND;
            end
          tws_pkg::S_SEND:
            if (rise)
            begin
              bitCnt_q <= bitCnt_q + 4'h1;
              if (sdaOeN_q && !sdaNow)
              begin
                sdaOeN_q <= 1'h1;
                state_q  <= tws_pkg::S_IDLE;
              end
            end
            else if (fall)
            begin
              if (byteDone)
              begin
                sdaOeN_q <= 1'h1;
                state_q  <= tws_pkg::S_GETACK;
              end
              else
              begin
                shift_q  <= {shift_q[6:0], 1'h1};
                sdaOeN_q <= shift_q[6];
              end
            end
          tws_pkg::S_GETACK:
            if (rise)
              ackN_q <= sdaNow;
            else if (fall)
            begin
              // acknowledged: fetch the next byte; otherwise the master ends
              if (!ackN_q)
              begin
                sclOeN_q <= 1'h0;
                state_q  <= tws_pkg::S_LOAD;
              end
              else
                state_q <= tws_pkg::S_IDLE;
            end
          default:
          begin
            sclOeN_q <= 1'h1;
            sdaOeN_q <= 1'h1;
          end
        endcase
    end

  assign bus.sSclOut = 1'h0;
  assign bus.sSdaOut = 1'h0;
  assign bus.sSclOeN = sclOeN_q;
  assign bus.sSdaOeN = sdaOeN_q;
  assign wrValid     = wrValid_q;
  assign wrData      = wrData_q;
  assign rdReady     = rdReady_q;

endmodule

// *** tb/tws_sva.sv ***
/*
  Bus-level assertions for the two-wire link between master and far end.
  Assumes plain interface signals and an asynchronous active-low reset.
*/
module tws_sva
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic mSclOut,
  input wire logic mSclOeN,
  input wire logic mSdaOut,
  input wire logic mSdaOeN,
  input wire logic sSclOut,
  input wire logic sSclOeN,
  input wire logic sSdaOut,
  input wire logic sSdaOeN
);
  timeunit 1ns;
  timeprecision 1ps;

  // one clock domain, so clock and disable are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // output values are fixed low; only the enables move a line
  od_low_only_a: assert property (!(mSclOut | mSdaOut | sSclOut | sSdaOut))
    else $error("bus line driven high");
  start_shape_a: assert property ($fell(mSdaOeN) && scl |-> mSclOeN [*8])
    else $error("scl not held high after start");
  data_setup_a: assert property ($changed(mSdaOeN) && !scl |-> !scl [*8])
    else $error("master data change too near scl rise");
  stop_shape_a: assert property ($rose(mSdaOeN) && scl && $past(scl) |-> scl [*8])
    else $error("scl not high after stop");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  // the wired scl follows the enable at once, so look at the level before the pull
  master_scl_wait_a: assert property ($fell(mSclOeN) |-> $past(scl))
    else $error("scl pulled before seen high");
  slave_stretch_a: assert property ($fell(sSclOeN) |-> !$past(scl))
    else $error("slave grabbed scl while high");
  slave_sda_low_a: assert property ($changed(sSdaOeN) |-> !scl)
    else $error("slave changed sda while scl high");
endmodule

// *** tb/two_wire_serial_protocol_engine_tb_top.sv ***
/*
  Self-checking bench: master end and far end joined by the bus interface.
  Assumes commands complete within a few thousand cycles each.
*/
module two_wire_serial_protocol_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin numErrors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
  logic               ref_clk, reset_n, cmdValid, cmdLast, rxReady;
  tws_pkg::tws_cmd_t  cmdCode;
  logic [7:0]         cmdData, rxData, wrData, gotData, expRd, d;
  logic               cmdReady, done, nack, arbLost, busBusy, rxValid, wrValid, rdReady, rw, bad;
  logic               wrReady = 1'b0;
  logic [7:0]         rdData = 8'hC3;
  int                 numErrors, cmpCount, stall, hold;
  // rows: direction, wrong address, data byte
  logic [9:0]         rows [4] = '{10'h0A5, 10'h03C, 10'h200, 10'h15A};

  tws_bus_if i_tws_bus_if();
  tws_master i_tws_master(.ref_clk(ref_clk), .reset_n(reset_n), .bus(i_tws_bus_if.master), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdData(cmdData), .cmdLast(cmdLast), .done(done), .nack(nack),
    .arbLost(arbLost), .busBusy(busBusy), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));
  tws_far_end i_tws_far_end(.ref_clk(ref_clk), .reset_n(reset_n), .bus(i_tws_bus_if.slave), .wrValid(wrValid),
    .wrReady(wrReady), .wrData(wrData), .rdValid(1'b1), .rdReady(rdReady), .rdData(rdData));
  tws_sva i_tws_sva(.ref_clk(ref_clk), .reset_n(reset_n), .scl(i_tws_bus_if.scl),
    .mSclOut(i_tws_bus_if.mSclOut), .mSclOeN(i_tws_bus_if.mSclOeN), .mSdaOut(i_tws_bus_if.mSdaOut),
    .mSdaOeN(i_tws_bus_if.mSdaOeN), .sSclOut(i_tws_bus_if.sSclOut), .sSclOeN(i_tws_bus_if.sSclOeN),
    .sSdaOut(i_tws_bus_if.sSdaOut), .sSdaOeN(i_tws_bus_if.sSdaOeN));

  // far-end user: stalls written bytes up to 120 cycles, less than the master's own scl low time, so scl never stretches; next byte after each fetch
  always @(negedge ref_clk)
  begin
    hold <= wrValid ? hold + 1 : 0;
    wrReady <= wrValid && hold >= stall;
    if (rdReady)
      rdData <= rdData + 8'h01;
  end

  // capture written bytes at the edge the far end hands them over
  always @(posedge ref_clk)
    if (wrValid && wrReady)
      gotData <= wrData;

  task automatic endOfTest;
    if (numErrors == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // offer one command at a falling edge, wait for its completion
  task automatic issue(input tws_pkg::tws_cmd_t c, input logic [7:0] v, input logic l);
    int n;
    n = 0;
    cmdCode = c;
    cmdData = v;
    cmdLast = l;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && n++ < 9000) @(negedge ref_clk);
    @(negedge ref_clk);
    cmdValid = 1'b0;
    while (done !== 1'b1 && arbLost !== 1'b1 && n++ < 9000) @(negedge ref_clk);
    `CHK(n < 9000, 1'b1)
    `CHK(arbLost, 1'b0)
  endtask

  // let a fresh push land, then take one byte and compare it in order
  task automatic pop;
    @(negedge ref_clk);
    `CHK(rxValid, 1'b1)
    `CHK(rxData, expRd)
    rxReady = 1'b1;
    @(negedge ref_clk);
    rxReady = 1'b0;
    expRd++;
  endtask

  // hang guard: longer than the whole sequence should take
  initial
  begin
    #(8 * 95000);
    numErrors++;
    endOfTest();
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // main sequence: reset, table rows, then the awkward cases
  initial
  begin
    {reset_n, cmdValid, cmdLast, rxReady, cmdData} = '0;
    cmdCode = tws_pkg::CMD_START;
    expRd = 8'hC3;
    stall = 0;
    repeat (16) @(negedge ref_clk);
    `CHK({i_tws_bus_if.mSclOeN, i_tws_bus_if.mSdaOeN, cmdReady, busBusy}, 4'hC)
    reset_n = 1'b1;
    issue(tws_pkg::CMD_WRITE, 8'h00, 1'b0);
    `CHK({i_tws_bus_if.scl, busBusy}, 2'h2)
    for (int i = 0; i < 4; i++)
    begin
      {rw, bad, d} = rows[i];
      stall = i * 40;
      issue(tws_pkg::CMD_START, 8'h00, 1'b0);
      `CHK(busBusy, 1'b1)
      issue(tws_pkg::CMD_WRITE, {tws_pkg::SLAVE_ADDR ^ {6'h00, bad}, rw}, 1'b0);
      `CHK(nack, bad)
      if (!bad && !rw)
      begin
        issue(tws_pkg::CMD_WRITE, d, 1'b0);
        `CHK(nack, 1'b0)
        `CHK(gotData, d)
      end
      if (!bad && rw)
      begin
        issue(tws_pkg::CMD_READ, 8'h00, 1'b1);
        `CHK(nack, 1'b1)
        pop();
      end
      issue(tws_pkg::CMD_STOP, 8'h00, 1'b0);
      repeat (8) @(negedge ref_clk);
      `CHK(busBusy, 1'b0)
    end
    // combined message: write, repeated start, reads until the buffer refuses
    issue(tws_pkg::CMD_START, 8'h00, 1'b0);
    issue(tws_pkg::CMD_WRITE, {tws_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    issue(tws_pkg::CMD_WRITE, 8'h81, 1'b0);
    `CHK(gotData, 8'h81)
    issue(tws_pkg::CMD_START, 8'h00, 1'b0);
    `CHK(busBusy, 1'b1)
    issue(tws_pkg::CMD_WRITE, {tws_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      issue(tws_pkg::CMD_READ, 8'h00, k == 15);
      `CHK(nack, k == 15)
    end
    repeat (200) @(negedge ref_clk);
    `CHK(cmdReady, 1'b0)
    repeat (16) pop();
    issue(tws_pkg::CMD_STOP, 8'h00, 1'b0);
    endOfTest();
  end
endmodule
